// ==== shared/spo_pkg.sv ====
// spo_pkg: constants shared by the sensor pixel output end and its receiver end.
// assumes a single 200 MHz core clock on both ends.
package spo_pkg;
	localparam int CLK_MHZ = 200; // core clock rate
	localparam int PIX_W = 10; // one raw pixel word
	localparam int CNT_W = 12; // line and column counters
	localparam int PCLK_DIV = 4; // core clocks per pixel clock (50 MHz)
	localparam logic [1:0] PCLK_RISE_PH = 2'h0; // divider phase of the pixel clock rise
	localparam logic [1:0] PCLK_UPD_PH = 2'h2; // outputs change half a period before it
	localparam int MCLK_MHZ = 20; // master clock made by the receiver end
	localparam logic [3:0] MCLK_HALF = 4'(CLK_MHZ / MCLK_MHZ / 2); // core clocks per half period
	localparam logic [CNT_W-1:0] OUT_LINES = 12'd1556; // lines per frame out
	localparam logic [CNT_W-1:0] OUT_COLS = 12'd2696; // pixel columns per line out
	localparam int FRAME_WIDTH_DEF = 2800; // line period in pixel clocks
	localparam int FRAME_HEIGHT_DEF = 1600; // frame period in lines
	localparam logic [CNT_W-1:0] ARRAY_ROWS = 12'd1560; // full array size
	localparam logic [CNT_W-1:0] ARRAY_COLS = 12'd2704;
	localparam logic [CNT_W-1:0] OB_ROWS = 12'd32; // optical black rows on top
	localparam logic [CNT_W-1:0] BOUND = 12'd4; // boundary ring width
	localparam logic [CNT_W-1:0] ACT_ROWS = 12'd1520; // active image height
	localparam logic [CNT_W-1:0] ACT_COLS = 12'd2688; // active image width
	localparam logic [CNT_W-1:0] DUMMY_COLS = 12'd4; // unused columns before the boundary
	localparam logic [PIX_W-1:0] BLACK_LEVEL = 10'h040; // value sent for optical black pixels
	localparam logic [7:0] SLAVE_WR_LOW = 8'h80; // write address, select pin low
	localparam logic [7:0] SLAVE_WR_HIGH = 8'h88; // write address, select pin high
	localparam int FIFO_DEPTH = 16; // pixel buffer depth
endpackage : spo_pkg

// ==== shared/spo_link_if.sv ====
// spo_link_if: pins between the sensor end and the receiver end.
// assumes both ends run on their own core clocks; the interface resolves the wires.
`timescale 1ns/100ps
interface spo_link_if;
	import spo_pkg::*;
	logic master_clock_in; // receiver to sensor master clock
	logic power_down_pin; // high puts the sensor in power-down
	logic reset_n_pin; // low holds the sensor in reset
	logic sel_out; // slave address select, driven by the receiver
	logic sel_oe_n; // low while the receiver drives it
	logic slave_addr_select; // resolved level, pulled low when undriven
	logic pclk; // pixel clock from the sensor
	logic line_valid; // line data valid
	logic [PIX_W-1:0] pixel_data; // pixel word
	logic fs_dev_out; // frame sync, sensor side driver
	logic fs_dev_oe_n;
	logic fs_host_out; // frame sync, receiver side driver
	logic fs_host_oe_n;
	logic frame_sync; // resolved frame sync wire, low when undriven
	assign slave_addr_select = !sel_oe_n && sel_out;
	assign frame_sync = (!fs_dev_oe_n && fs_dev_out) || (!fs_host_oe_n && fs_host_out);
	modport dev (input master_clock_in, power_down_pin, reset_n_pin, slave_addr_select,
		frame_sync, output pclk, line_valid, pixel_data, fs_dev_out, fs_dev_oe_n);
	modport host (output master_clock_in, power_down_pin, reset_n_pin, sel_out, sel_oe_n,
		fs_host_out, fs_host_oe_n, input pclk, line_valid, pixel_data, frame_sync);
endinterface : spo_link_if

// ==== logic/spo_fifo.sv ====
// spo_fifo: small synchronous pixel buffer with valid/ready on both sides.
// assumes one clock; clear empties it in one cycle.
`timescale 1ns/100ps
module spo_fifo #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic clear,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH]; // storage
	logic [AW-1:0] wr_ptr_reg; // write slot
	logic [AW-1:0] rd_ptr_reg; // read slot
	logic [AW:0] count_reg; // words held
	logic push;
	logic pop;

	assign in_ready = (count_reg != (AW+1)'(DEPTH));
	assign out_valid = (count_reg != '0);
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem[rd_ptr_reg];

	// storage write, no reset needed on the array
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr_reg] <= in_data;
		end
	end

	// pointers and fill level
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end else if (clear) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end else begin
			if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
			if (pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
			count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : spo_fifo

// ==== logic/spo_sensor.sv ====
// spo_sensor: sensor end of the parallel pixel link: frame/line timing, pixel clock,
// rolling reset pointer, array mapping and a buffered pixel source.
// assumes the receiver drives power-down, reset and address select; all pins are resynced.
// Functional notes
// - one 10-bit word per pixel clock
// - pixel words qualified only by line valid
// - default frame 1556 lines of 2696 columns
// - frame sync high after last line, low before next
// - frame sync pin may act as input
// - outputs sampled on pixel clock rising edge
// - separate polarity inverts for three outputs
// - programmable pixel clock delay versus data
// - line = width clocks, frame = height lines
// - power-down input high enters power-down
// - reset pin low holds reset, defaults after
// - address select pulled low, picks address pair
// - hdr: two exposures, staggered long/short frames
// - first 32 array rows are optical black
// - 2688x1520 active plus 4-pixel boundary ring
// - rolling reset then read; exposure is gap
// - bayer order from window, address, mirror, flip
// - host supplies one 6 to 27 MHz clock
// - column 0 row 0 at upper right
// - host keeps long plus short within height
// - external sync input aligns frame timing
`timescale 1ns/100ps
module spo_sensor import spo_pkg::*; #(
	parameter logic [CNT_W-1:0] FRAME_WIDTH = CNT_W'(FRAME_WIDTH_DEF),
	parameter logic [CNT_W-1:0] FRAME_HEIGHT = CNT_W'(FRAME_HEIGHT_DEF)
) (
	input wire logic clk,
	input wire logic reset_n,
	spo_link_if.dev link,
	input wire logic hdr_en,
	input wire logic [CNT_W-1:0] exp_long,
	input wire logic [CNT_W-1:0] exp_short,
	input wire logic lv_invert,
	input wire logic fs_invert,
	input wire logic pclk_invert,
	input wire logic [1:0] pclk_delay,
	input wire logic fsync_input_en,
	input wire logic fsync_slave_en,
	input wire logic mirror_en,
	input wire logic vflip_en,
	input wire logic [CNT_W-1:0] horiz_window_start,
	input wire logic [CNT_W-1:0] vert_window_start,
	input wire logic [CNT_W-1:0] horiz_address_start,
	output logic [1:0] bayer_order,
	output logic hdr_long_frame,
	output logic black_row,
	output logic active_pixel,
	output logic [CNT_W-1:0] reset_row_addr,
	output logic [7:0] slave_addr_write,
	output logic in_power_down
);
	// array row of an output line; row 0 is the top edge, flip reverses
	function automatic logic [CNT_W-1:0] arr_row(input logic [CNT_W-1:0] line,
		input logic [CNT_W-1:0] vws, input logic flip);
		logic [CNT_W-1:0] r;
		r = line + vws;
		arr_row = flip ? (ARRAY_ROWS - 1'b1 - r) : r;
	endfunction : arr_row

	// array column of an output pixel; column 0 sits at the right edge
	function automatic logic [CNT_W-1:0] arr_col(input logic [CNT_W-1:0] col,
		input logic [CNT_W-1:0] hws, input logic [CNT_W-1:0] has, input logic mir);
		logic [CNT_W-1:0] c;
		c = col + hws + has;
		arr_col = mir ? (ARRAY_COLS - 1'b1 - c) : c;
	endfunction : arr_col

	logic [3:0] pin_s1_reg; // first sync stage, read only by the second
	logic [3:0] pin_s2_reg; // {frame_sync, select, reset pin, power-down}
	logic rstpin_q_reg; // previous synced reset pin
	logic fs_q_reg; // previous synced frame sync
	logic [1:0] div_reg; // pixel clock divider phase
	logic [3:0] pclk_dly_reg; // delayed copies of the raw pixel clock
	logic [CNT_W-1:0] col_reg; // column within the line period
	logic [CNT_W-1:0] row_reg; // line within the frame period
	logic [CNT_W-1:0] gen_col_reg; // pixel source position
	logic [CNT_W-1:0] gen_row_reg;
	logic pclk_out_reg;
	logic lv_out_reg;
	logic fs_out_reg;
	logic [PIX_W-1:0] data_out_reg;
	logic hold; // reset pin low or powered down
	logic upd; // pixel output update point
	logic pclk_raw;
	logic in_line; // current position carries a pixel
	logic ext_start; // frame start seen on the sync input
	logic resync;
	logic [CNT_W-1:0] g_arow;
	logic [CNT_W-1:0] g_acol;
	logic [CNT_W-1:0] o_arow;
	logic [CNT_W-1:0] o_acol;
	logic [PIX_W-1:0] gen_pix;
	logic gen_ready;
	logic fifo_valid;
	logic [PIX_W-1:0] fifo_data;

	// all pins come from the other party: two flops before use
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pin_s1_reg <= 4'h4;
			pin_s2_reg <= 4'h4;
		end else begin
			pin_s1_reg <= {link.frame_sync, link.slave_addr_select, link.reset_n_pin,
				link.power_down_pin};
			pin_s2_reg <= pin_s1_reg;
		end
	end

	assign hold = !pin_s2_reg[1] || pin_s2_reg[0];
	assign in_power_down = pin_s2_reg[0];
	assign upd = (div_reg == PCLK_UPD_PH) && !hold;
	assign pclk_raw = (div_reg == PCLK_RISE_PH) || (div_reg == PCLK_RISE_PH + 2'h1);
	assign in_line = (row_reg < OUT_LINES) && (col_reg < OUT_COLS);
	// frame start is the sync falling edge after polarity is removed
	assign ext_start = fsync_input_en && fsync_slave_en && fs_q_reg
		&& !(pin_s2_reg[3] ^ fs_invert);
	assign resync = ext_start || hold;

	// edge history; the select level is caught as the reset pin rises
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rstpin_q_reg <= 1'b1;
			fs_q_reg <= 1'b0;
			slave_addr_write <= SLAVE_WR_LOW;
		end else begin
			rstpin_q_reg <= pin_s2_reg[1];
			fs_q_reg <= pin_s2_reg[3] ^ fs_invert;
			if (pin_s2_reg[1] && !rstpin_q_reg) begin
				slave_addr_write <= pin_s2_reg[2] ? SLAVE_WR_HIGH : SLAVE_WR_LOW;
			end
		end
	end

	// pixel clock divider and its delay line
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			div_reg <= '0;
			pclk_dly_reg <= '0;
		end else begin
			// a restart realigns the phase, so a word is buffered before the first update
			div_reg <= resync ? '0 : div_reg + 2'h1; // PCLK_DIV of 4 wraps naturally
			pclk_dly_reg <= {pclk_dly_reg[2:0], pclk_raw};
		end
	end

	// line and frame counters step once per pixel clock
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			col_reg <= '0;
			row_reg <= '0;
			hdr_long_frame <= 1'b1;
		end else if (resync) begin
			col_reg <= '0;
			row_reg <= '0;
			if (hold) hdr_long_frame <= 1'b1;
		end else if (upd) begin
			if (col_reg == FRAME_WIDTH - 1'b1) begin
				col_reg <= '0;
				if (row_reg == FRAME_HEIGHT - 1'b1) begin
					row_reg <= '0;
					hdr_long_frame <= hdr_en ? !hdr_long_frame : 1'b1;
				end else begin
					row_reg <= row_reg + 1'b1;
				end
			end else begin
				col_reg <= col_reg + 1'b1;
			end
		end
	end

	// rolling shutter: a row is reset the exposure ahead of its readout
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			reset_row_addr <= '0;
		end else begin
			reset_row_addr <= row_reg + (hdr_long_frame ? exp_long : exp_short);
			if (row_reg + (hdr_long_frame ? exp_long : exp_short) >= FRAME_HEIGHT) begin
				reset_row_addr <= row_reg + (hdr_long_frame ? exp_long : exp_short)
					- FRAME_HEIGHT;
			end
		end
	end

	// pixel source: runs ahead of the output and stalls on a full buffer
	assign g_arow = arr_row(gen_row_reg, vert_window_start, vflip_en);
	assign g_acol = arr_col(gen_col_reg, horiz_window_start, horiz_address_start, mirror_en);
	assign gen_pix = (g_arow < OB_ROWS) ? BLACK_LEVEL : {g_arow[4:0] ^ g_acol[4:0], g_acol[4:0]};
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			gen_col_reg <= '0;
			gen_row_reg <= '0;
		end else if (resync) begin
			gen_col_reg <= '0;
			gen_row_reg <= '0;
		end else if (gen_ready) begin
			if (gen_col_reg == OUT_COLS - 1'b1) begin
				gen_col_reg <= '0;
				gen_row_reg <= (gen_row_reg == OUT_LINES - 1'b1) ? '0 : gen_row_reg + 1'b1;
			end else begin
				gen_col_reg <= gen_col_reg + 1'b1;
			end
		end
	end

	// buffer between the source and the link; the link drains one word per pixel
	spo_fifo #(.WIDTH(PIX_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk(clk),
		.reset_n(reset_n),
		.clear(resync),
		.in_valid(!resync),
		.in_ready(gen_ready),
		.in_data(gen_pix),
		.out_valid(fifo_valid),
		.out_ready(upd && in_line),
		.out_data(fifo_data)
	);

	// output pins change half a pixel clock before its rising edge
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			lv_out_reg <= 1'b0;
			fs_out_reg <= 1'b0;
			data_out_reg <= '0;
		end else if (resync) begin
			lv_out_reg <= 1'b0; // quiet while held or restarting, so a cut line ends
			fs_out_reg <= 1'b0;
			data_out_reg <= '0;
		end else if (upd) begin
			lv_out_reg <= in_line && fifo_valid;
			fs_out_reg <= (row_reg >= OUT_LINES) && (row_reg < FRAME_HEIGHT - 1'b1);
			// a dry buffer must not leak a stale word onto an unqualified bus
			data_out_reg <= (in_line && fifo_valid) ? fifo_data : '0;
		end
	end

	// pixel clock out, optionally delayed by whole core cycles
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pclk_out_reg <= 1'b0;
		end else if (hold) begin
			pclk_out_reg <= 1'b0;
		end else begin
			pclk_out_reg <= (pclk_delay == 2'h0) ? pclk_raw : pclk_dly_reg[pclk_delay - 2'h1];
		end
	end

	assign link.pclk = pclk_out_reg ^ pclk_invert;
	assign link.line_valid = lv_out_reg ^ lv_invert;
	assign link.pixel_data = data_out_reg;
	assign link.fs_dev_out = fs_out_reg ^ fs_invert;
	assign link.fs_dev_oe_n = fsync_input_en;

	// status for the array position now on the pins
	assign o_arow = arr_row(row_reg, vert_window_start, vflip_en);
	assign o_acol = arr_col(col_reg, horiz_window_start, horiz_address_start, mirror_en);
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			black_row <= 1'b0;
			active_pixel <= 1'b0;
			bayer_order <= '0;
		end else if (upd) begin
			black_row <= o_arow < OB_ROWS;
			active_pixel <= (o_arow >= OB_ROWS + BOUND) && (o_arow < OB_ROWS + BOUND + ACT_ROWS)
				&& (o_acol >= DUMMY_COLS + BOUND) && (o_acol < DUMMY_COLS + BOUND + ACT_COLS);
			bayer_order <= {o_arow[0], o_acol[0]};
		end
	end
endmodule : spo_sensor

// ==== logic/spo_receiver.sv ====
// spo_receiver: receiver end: makes the master clock, drives control pins and
// captures pixels on the sensor's pixel clock found by oversampling.
// assumes the pixel clock is no faster than a quarter of the core clock.
`timescale 1ns/100ps
module spo_receiver import spo_pkg::*; (
	input wire logic clk,
	input wire logic reset_n,
	spo_link_if.host link,
	input wire logic power_down_req,
	input wire logic sensor_reset_req,
	input wire logic addr_sel_high,
	input wire logic sync_drive_en,
	input wire logic sync_level,
	input wire logic lv_invert,
	input wire logic fs_invert,
	input wire logic pclk_invert,
	output logic pix_valid,
	output logic [PIX_W-1:0] pix_data,
	output logic [CNT_W-1:0] pix_col,
	output logic [CNT_W-1:0] pix_row,
	output logic line_end,
	output logic frame_start,
	output logic frame_end
);
	logic [3:0] mclk_cnt_reg; // master clock half period counter
	logic mclk_reg;
	logic [PIX_W+2:0] s1_reg; // first sync stage
	logic [PIX_W+2:0] s2_reg; // {pclk, line_valid, frame_sync, data}
	logic pclk_q_reg;
	logic lv_q_reg;
	logic fs_q_reg;
	logic pclk_s;
	logic lv_s;
	logic fs_s;
	logic rise;

	// master clock of 20 MHz, inside the 6 to 27 MHz band
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			mclk_cnt_reg <= '0;
			mclk_reg <= 1'b0;
		end else if (mclk_cnt_reg == MCLK_HALF - 4'h1) begin
			mclk_cnt_reg <= '0;
			mclk_reg <= !mclk_reg;
		end else begin
			mclk_cnt_reg <= mclk_cnt_reg + 4'h1;
		end
	end

	assign link.master_clock_in = mclk_reg;
	assign link.power_down_pin = power_down_req;
	assign link.reset_n_pin = !sensor_reset_req;
	assign link.sel_out = 1'b1;
	assign link.sel_oe_n = !addr_sel_high; // released means pulled low
	assign link.fs_host_out = sync_level;
	assign link.fs_host_oe_n = !sync_drive_en;

	// link pins are foreign: two flops before use
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s1_reg <= '0;
			s2_reg <= '0;
		end else begin
			s1_reg <= {link.pclk, link.line_valid, link.frame_sync, link.pixel_data};
			s2_reg <= s1_reg;
		end
	end

	assign pclk_s = s2_reg[PIX_W+2] ^ pclk_invert;
	assign lv_s = s2_reg[PIX_W+1] ^ lv_invert;
	assign fs_s = s2_reg[PIX_W] ^ fs_invert;
	assign rise = pclk_s && !pclk_q_reg;

	// capture on each rising pixel clock edge; data only while line valid
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pclk_q_reg <= 1'b0;
			lv_q_reg <= 1'b0;
			fs_q_reg <= 1'b0;
			pix_valid <= 1'b0;
			pix_data <= '0;
			pix_col <= '0;
			pix_row <= '0;
			line_end <= 1'b0;
			frame_start <= 1'b0;
			frame_end <= 1'b0;
		end else begin
			pclk_q_reg <= pclk_s;
			pix_valid <= 1'b0;
			line_end <= 1'b0;
			frame_start <= 1'b0;
			frame_end <= 1'b0;
			if (rise) begin
				lv_q_reg <= lv_s;
				fs_q_reg <= fs_s;
				if (lv_s) begin
					pix_valid <= 1'b1;
					pix_data <= s2_reg[PIX_W-1:0];
					pix_col <= lv_q_reg ? pix_col + 1'b1 : '0;
				end
				if (lv_q_reg && !lv_s) begin
					line_end <= 1'b1;
					pix_row <= pix_row + 1'b1;
				end
				if (fs_s && !fs_q_reg) frame_end <= 1'b1;
				if (!fs_s && fs_q_reg) begin
					frame_start <= 1'b1;
					pix_row <= '0;
				end
			end
		end
	end
endmodule : spo_receiver

// ==== testbench/spo_link_sva.sv ====
// spo_link_sva: timing checks on the pixel link between sensor end and receiver end.
// assumes all polarity inverts and the pixel clock delay are left at zero.
`timescale 1ns/100ps
module spo_link_sva import spo_pkg::*; #(
	parameter int LV_CYC = 10784,
	parameter int LINE_CYC = 11200
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic pclk,
	input wire logic line_valid,
	input wire logic [PIX_W-1:0] pixel_data,
	input wire logic power_down_pin,
	input wire logic reset_n_pin,
	input wire logic fs_dev_oe_n,
	input wire logic fs_host_oe_n
);
	logic hold; // pins that stop or restart the sensor timing
	logic [3:0] quiet_cnt; // nonzero shortly after a hold
	logic [15:0] lv_len; // core cycles line valid has stayed high
	logic [15:0] per_cnt; // core cycles since the last line start
	logic per_seen; // a line start has been seen since the last hold

	// an external sync drive may restart the frame, so it is treated like a hold
	assign hold = power_down_pin || !reset_n_pin || !fs_host_oe_n;

	// the pin synchronisers need a few cycles to drain after a hold drops
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) quiet_cnt <= 4'hf;
		else if (hold) quiet_cnt <= 4'hf;
		else if (quiet_cnt != 4'h0) quiet_cnt <= quiet_cnt - 4'h1;
	end

	// length of the current line valid pulse
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) lv_len <= 16'h0000;
		else if (line_valid) lv_len <= lv_len + 16'h0001;
		else lv_len <= 16'h0000;
	end

	// distance between line starts; cut short by any hold
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			per_cnt <= 16'h0000;
			per_seen <= 1'b0;
		end else if (hold) begin
			per_seen <= 1'b0;
		end else if ($rose(line_valid)) begin
			per_cnt <= 16'h0001;
			per_seen <= 1'b1;
		end else begin
			per_cnt <= per_cnt + 16'h0001;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	sequence s_pclk_high;
		pclk ##1 !pclk;
	endsequence
	sequence s_word_held;
		$stable(pixel_data) && $stable(line_valid);
	endsequence

	a_pclk_high_time: assert property ($rose(pclk) && quiet_cnt == 4'h0 |=> s_pclk_high)
		else $error("pixel clock high time wrong");
	a_word_held_edge: assert property ($rose(pclk) && quiet_cnt == 4'h0
		|-> s_word_held ##1 s_word_held)
		else $error("pixel word moved at the pixel clock rise");
	a_idle_data_zero: assert property (!line_valid |-> pixel_data == '0)
		else $error("pixel data not quiet outside line valid");
	a_line_word_count: assert property ($fell(line_valid) && quiet_cnt == 4'h0
		|-> lv_len == LV_CYC)
		else $error("line valid length wrong");
	a_line_period_len: assert property ($rose(line_valid) && per_seen && !hold
		|-> per_cnt == LINE_CYC)
		else $error("line period wrong");
	a_power_down_pin_quiet_out: assert property (power_down_pin && $past(power_down_pin, 4) |-> !line_valid)
		else $error("line valid during power-down");
	a_reset_quiet_out: assert property (!reset_n_pin && !$past(reset_n_pin, 4) |-> !line_valid)
		else $error("line valid during sensor reset");
	a_sync_pin_free: assert property (!fs_host_oe_n |-> fs_dev_oe_n)
		else $error("sensor drives frame sync while it is an input");
endmodule : spo_link_sva

// ==== testbench/sensor_pixel_output_timing_tb.sv ====
// sensor_pixel_output_timing_tb: both link ends joined, driven through their user ports.
// assumes 3-line frames so whole frames fit a short run; inverts and clock delay off.
`timescale 1ns/100ps
module sensor_pixel_output_timing_tb import spo_pkg::*;;
	localparam int LINE_CYC = 2700 * PCLK_DIV; // line period in core cycles
	localparam int LV_CYC = int'(OUT_COLS) * PCLK_DIV; // line valid length
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic pd_req = 1'b0, rst_req = 1'b0, sel_high = 1'b0; // receiver control requests
	logic sync_en = 1'b0, sync_lvl = 1'b0, fs_in_en = 1'b0, slave_en = 1'b0; // sync setup
	logic hdr_en = 1'b1, mirror = 1'b0, vflip = 1'b0; // sensor readout modes
	logic lv_inv = 1'b0, fs_inv = 1'b0, pclk_inv = 1'b0; // polarity, same on both ends
	logic [1:0] pclk_dly = 2'h0; // pixel clock delay
	logic [CNT_W-1:0] exp_l = 12'h001, exp_s = 12'h001; // exposures in lines
	logic [CNT_W-1:0] hws_set = 12'h000, vws_set = 12'h000, has_set = 12'h000; // window starts
	logic pix_valid, line_end, hdr_long, in_pd, h;
	logic [PIX_W-1:0] pix_data;
	logic [7:0] slave_addr;
	int bad_count = 0;
	int check_count = 0;
	int cyc = 0;
	int cnt, blk, t0, t1;

	always #2.5 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;

	spo_link_if link();
	// short frame height keeps whole frames in the run; long plus short exposure fits it
	spo_sensor #(.FRAME_WIDTH(12'd2700), .FRAME_HEIGHT(12'd3)) i_spo_sensor (.clk(clk),
		.reset_n(reset_n), .link(link), .hdr_en(hdr_en), .exp_long(exp_l), .exp_short(exp_s),
		.lv_invert(lv_inv), .fs_invert(fs_inv), .pclk_invert(pclk_inv), .pclk_delay(pclk_dly),
		.fsync_input_en(fs_in_en), .fsync_slave_en(slave_en), .mirror_en(mirror),
		.vflip_en(vflip), .horiz_window_start(hws_set), .vert_window_start(vws_set),
		.horiz_address_start(has_set),
		.bayer_order(), .hdr_long_frame(hdr_long), .black_row(), .active_pixel(),
		.reset_row_addr(), .slave_addr_write(slave_addr), .in_power_down(in_pd));
	spo_receiver i_spo_receiver (.clk(clk), .reset_n(reset_n), .link(link),
		.power_down_req(pd_req), .sensor_reset_req(rst_req), .addr_sel_high(sel_high),
		.sync_drive_en(sync_en), .sync_level(sync_lvl), .lv_invert(lv_inv), .fs_invert(fs_inv),
		.pclk_invert(pclk_inv), .pix_valid(pix_valid), .pix_data(pix_data), .pix_col(), .pix_row(),
		.line_end(line_end), .frame_start(), .frame_end());
	spo_link_sva #(.LV_CYC(LV_CYC), .LINE_CYC(LINE_CYC)) i_spo_link_sva (.clk(clk),
		.reset_n(reset_n), .pclk(link.pclk), .line_valid(link.line_valid),
		.pixel_data(link.pixel_data), .power_down_pin(link.power_down_pin),
		.reset_n_pin(link.reset_n_pin), .fs_dev_oe_n(link.fs_dev_oe_n),
		.fs_host_oe_n(link.fs_host_oe_n));

	// verdict and end of run
	task automatic stop_test();
		if (bad_count == 0 && check_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : stop_test

	// compare one observed value
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value %s expected %0h seen %0h", what, exp, got);
		end
	endtask : check

	// signals that waits can watch
	function automatic logic sig(input int k);
		case (k)
			0: return pix_valid;
			1: return link.line_valid;
			default: return hdr_long;
		endcase
	endfunction : sig

	// bounded wait on a level; running out ends the run as a mismatch
	task automatic wait_for(input int k, input logic lvl, input int lim);
		int n;
		n = 0;
		while (sig(k) !== lvl) begin
			@(negedge clk);
			n++;
			if (n > lim) begin
				bad_count++;
				$display("wrong value wait %0d expected %0d seen %0d", k, lvl, n);
				stop_test();
			end
		end
	endtask : wait_for

	// count the words of one line and how many carry the black level
	task automatic grab_line(output int c, output int b, output int t);
		int n;
		c = 0;
		b = 0;
		n = 0;
		wait_for(0, 1'b1, LINE_CYC);
		forever begin
			if (pix_valid === 1'b1) c++;
			if (pix_valid === 1'b1 && pix_data === BLACK_LEVEL) b++;
			if (line_end === 1'b1) break;
			// a line that never ends is a hang, not a short line
			if (n > 2 * LINE_CYC) begin
				bad_count++;
				$display("wrong value line_end expected 1 seen 0");
				stop_test();
			end
			@(negedge clk);
			n++;
		end
		t = cyc;
		// step past the last pulse so the next line starts clean
		@(negedge clk);
	endtask : grab_line

	initial begin
		repeat (20) @(posedge clk);
		reset_n <= 1'b1;
		repeat (10) @(negedge clk);
		check("slave_addr", 16'(SLAVE_WR_LOW), 16'(slave_addr));
		grab_line(cnt, blk, t0);
		check("line_words", 16'(OUT_COLS), cnt[15:0]);
		check("black_words", 16'(OUT_COLS), blk[15:0]);
		grab_line(cnt, blk, t1);
		check("line_period", 16'(LINE_CYC), 16'(t1 - t0));
		h = hdr_long;
		wait_for(2, !h, 3 * LINE_CYC);
		// external sync: release the pin, then drop it in mid-line to restart the frame
		@(posedge clk);
		fs_in_en <= 1'b1;
		slave_en <= 1'b1;
		repeat (10) @(negedge clk);
		check("fs_release", 16'h0001, 16'(link.fs_dev_oe_n));
		wait_for(1, 1'b1, LINE_CYC);
		repeat (400) @(posedge clk);
		sync_en <= 1'b1;
		sync_lvl <= 1'b1;
		repeat (20) @(posedge clk);
		sync_lvl <= 1'b0;
		wait_for(1, 1'b0, 40);
		wait_for(1, 1'b1, 200);
		repeat (50) @(posedge clk);
		sync_en <= 1'b0;
		repeat (10) @(posedge clk);
		fs_in_en <= 1'b0;
		slave_en <= 1'b0;
		// power-down stops all words, release resumes
		pd_req <= 1'b1;
		repeat (10) @(negedge clk);
		check("in_power_down", 16'h0001, 16'(in_pd));
		cnt = 0;
		repeat (200) begin
			@(negedge clk);
			if (pix_valid === 1'b1) cnt++;
		end
		check("pd_words", 16'h0000, cnt[15:0]);
		@(posedge clk);
		pd_req <= 1'b0;
		wait_for(0, 1'b1, 200);
		// sensor reset latches the address select level
		for (int s = 1; s >= 0; s--) begin
			@(posedge clk);
			sel_high <= 1'(s);
			rst_req <= 1'b1;
			repeat (10) @(posedge clk);
			rst_req <= 1'b0;
			repeat (10) @(negedge clk);
			check("slave_addr", 16'(s ? SLAVE_WR_HIGH : SLAVE_WR_LOW), 16'(slave_addr));
			wait_for(0, 1'b1, 200);
		end
		// a flipped readout starts at the bottom row, far from the optical black rows
		@(posedge clk);
		vflip <= 1'b1;
		rst_req <= 1'b1;
		repeat (10) @(posedge clk);
		rst_req <= 1'b0;
		grab_line(cnt, blk, t0);
		check("flip_words", 16'(OUT_COLS), cnt[15:0]);
		check("flip_black", 16'h0000, blk[15:0]);
		stop_test();
	end
endmodule : sensor_pixel_output_timing_tb
